/* rtl/usbi_pkg.sv */
// constants for the usb host interrupt event flags block
// assumes one 125 MHz clock shared with the command bus logic
//
// Overview of operation
// [RULE_01] events set sticky flags until software clears
// [RULE_02] irq needs flag, mask bit, global enable
// [RULE_03] write one clears flag, never sets
// [RULE_04] hardware only sets flags, never clears
// [RULE_05] flags read 03h, written 83h
// [RULE_06] mask read 04h, written 84h
// [RULE_07] bit 6: hub or port state changed
// [RULE_08] bit 5: frame counter bit 15 toggled
// [RULE_09] bit 4: non-usb system error detected
// [RULE_10] after fatal error, halt processing and signaling
// [RULE_11] software clears fatal flag after controller reset
// [RULE_12] bit 3: resume signaling starts from idle
// [RULE_13] no resume flag for software-entered resume
// [RULE_14] each frame start: sof token, bit 2
// [RULE_15] bit 0: schedule overrun in current frame
// [RULE_16] overrun also bumps two-bit overrun tally
// [RULE_17] mask bit position matches its flag
// [RULE_18] mask write sets ones, keeps zeros
// [RULE_19] mask read returns contents, no side effect
// [RULE_20] mask bit 31 one enables, zero ignored
// [RULE_21] mask-clear port 05h/85h clears ones
// [RULE_22] tally starts zero, wraps, counts regardless
// [RULE_23] reserved bits read zero, writes ignored
// [RULE_24] event beats simultaneous clear of flag
package usbi_pkg;
  // ********************************
  // command codes
  // ********************************
  localparam int CMD_W = 8;
  localparam int DATA_W = 32;
  localparam logic [7:0] CMD_RD_FLAGS = 8'h03;
  localparam logic [7:0] CMD_WR_FLAGS = 8'h83;
  localparam logic [7:0] CMD_RD_MASK = 8'h04;
  localparam logic [7:0] CMD_WR_MASK = 8'h84;
  localparam logic [7:0] CMD_RD_MCLR = 8'h05;
  localparam logic [7:0] CMD_WR_MCLR = 8'h85;
  // ********************************
  // field positions and reset values
  // ********************************
  localparam int BIT_SO = 0;
  localparam int BIT_FRAME_START = 2;
  localparam int BIT_RD = 3;
  localparam int BIT_FATAL_ERR = 4;
  localparam int BIT_FRAME_WRAP = 5;
  localparam int BIT_HUB_CHANGE = 6;
  localparam int BIT_GLOBAL_EN = 31;
  localparam int FRAME_MSB = 15;
  localparam logic [31:0] FLAG_VALID = 32'h0000007d;
  localparam logic [31:0] MASK_VALID = 32'h8000007d;
  localparam logic [31:0] FLAGS_RST = 32'h00000000;
  localparam logic [31:0] MASK_RST = 32'h00000000;
  localparam logic [1:0] TALLY_RST = 2'h0;
  localparam logic [1:0] TALLY_ONE = 2'h1;
  // bus access class of a command
  typedef enum logic [1:0] {
    ACC_NONE = 2'b00,
    ACC_READ = 2'b01,
    ACC_WRITE = 2'b10
  } usbi_acc_e;
endpackage

/* rtl/usbi_sync.sv */
// two-flop synchroniser for one asynchronous level
// assumes the clock enable of the host block
`timescale 1ns/1ps
module usbi_sync
  import usbi_pkg::*;
(
  input wire logic clk,
  input wire logic ce,
  input wire logic srst,
  input wire logic async_in,
  output logic sync_out
);
  typedef struct packed {
    logic s1;
    logic s2;
  } usbi_sync_s;
  usbi_sync_s s;
  usbi_sync_s next_s;
  // first stage feeds only the second
  always_comb begin
    next_s.s1 = async_in;
    next_s.s2 = s.s1;
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end
  assign sync_out = s.s2;
endmodule

/* rtl/usbi_change_det.sv */
// change detector: pulses when a watched word differs from last cycle
// assumes the word comes from logic on the same clock
`timescale 1ns/1ps
module usbi_change_det
  import usbi_pkg::*;
#(
  parameter int W = 32
) (
  input wire logic clk,
  input wire logic ce,
  input wire logic srst,
  input wire logic [W-1:0] value,
  output logic changed
);
  typedef struct packed {
    logic [W-1:0] prev;
    logic primed;
  } usbi_chg_s;
  usbi_chg_s s;
  usbi_chg_s next_s;
  // primed blocks a false change on the first cycle after reset
  always_comb begin
    next_s.prev = value;
    next_s.primed = 1'b1;
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      s <= '0;
    end else if (ce) begin
      s <= next_s;
    end
  end
  assign changed = s.primed && (value != s.prev);
endmodule

/* rtl/usbi_top.sv */
// interrupt event flags, mask and irq of the usb host controller
// assumes command bus and event sources share CLK, except RESUME_PIN
`timescale 1ns/1ps
module usbi_top
  import usbi_pkg::*;
(
  input wire logic CLK,
  input wire logic CE,
  input wire logic SRST,
  input wire logic HC_SW_RESET,
  input wire logic CMD_VALID,
  input wire logic [7:0] CMD_CODE,
  input wire logic [31:0] CMD_WDATA,
  output logic [31:0] RD_DATA,
  output logic RD_VALID,
  input wire logic [31:0] HUB_STATE,
  input wire logic [31:0] PORT1_STATE,
  input wire logic [31:0] PORT2_STATE,
  input wire logic [15:0] FRAME_NUMBER,
  input wire logic SYS_ERROR,
  input wire logic RESUME_PIN,
  input wire logic RESUME_ENTRY_SW,
  input wire logic FRAME_START,
  input wire logic SCHED_OVERRUN,
  output logic SOF_TOKEN,
  output logic [1:0] OVERRUN_TALLY,
  output logic PROCESS_HALT,
  output logic IRQ
);
  // ********************************
  // state
  // ********************************
  typedef struct packed {
    logic [31:0] flags;
    logic [31:0] mask;
    logic [1:0] tally;
    logic halt;
    logic sof;
    logic [31:0] rd_data;
    logic rd_valid;
    logic resume_d;
  } usbi_top_s;
  usbi_top_s s;
  usbi_top_s next_s;

  logic hub_chg;
  logic p1_chg;
  logic p2_chg;
  logic wrap_chg;
  logic resume_sync;
  logic [31:0] ev;
  logic [31:0] wr_mask_bits;
  usbi_acc_e acc;
  logic wr_flags;
  logic wr_mask;
  logic wr_mclr;
  logic any_read;

  // ********************************
  // event sources
  // ********************************
  usbi_change_det #(.W(32)) u_hub_chg (
    .clk(CLK),
    .ce(CE),
    .srst(SRST),
    .value(HUB_STATE),
    .changed(hub_chg)
  );
  usbi_change_det #(.W(32)) u_p1_chg (
    .clk(CLK),
    .ce(CE),
    .srst(SRST),
    .value(PORT1_STATE),
    .changed(p1_chg)
  );
  usbi_change_det #(.W(32)) u_p2_chg (
    .clk(CLK),
    .ce(CE),
    .srst(SRST),
    .value(PORT2_STATE),
    .changed(p2_chg)
  );
  // either direction of the msb counts as a wrap
  usbi_change_det #(.W(1)) u_wrap_chg (
    .clk(CLK),
    .ce(CE),
    .srst(SRST),
    .value(FRAME_NUMBER[FRAME_MSB]),
    .changed(wrap_chg)
  );
  // resume arrives straight from the usb lines
  usbi_sync u_resume_sync (
    .clk(CLK),
    .ce(CE),
    .srst(SRST),
    .async_in(RESUME_PIN),
    .sync_out(resume_sync)
  );

  // event vector in flag bit positions
  always_comb begin
    ev = 32'h00000000;
    ev[BIT_HUB_CHANGE] = hub_chg | p1_chg | p2_chg; // RULE_07
    ev[BIT_FRAME_WRAP] = wrap_chg; // RULE_08
    ev[BIT_FATAL_ERR] = SYS_ERROR; // RULE_09
    ev[BIT_RD] = resume_sync & ~s.resume_d & ~RESUME_ENTRY_SW; // RULE_12 RULE_13
    ev[BIT_FRAME_START] = FRAME_START; // RULE_14
    ev[BIT_SO] = SCHED_OVERRUN; // RULE_15
  end

  // ********************************
  // command decode
  // ********************************
  // the top bit of a code tells write from read
  always_comb begin
    acc = ACC_NONE;
    if (CMD_VALID) begin
      acc = CMD_CODE[CMD_W-1] ? ACC_WRITE : ACC_READ;
    end
  end
  assign wr_flags = (acc == ACC_WRITE) && (CMD_CODE == CMD_WR_FLAGS); // RULE_05
  assign wr_mask = (acc == ACC_WRITE) && (CMD_CODE == CMD_WR_MASK); // RULE_06
  assign wr_mclr = (acc == ACC_WRITE) && (CMD_CODE == CMD_WR_MCLR); // RULE_21
  assign any_read = (acc == ACC_READ);
  // reserved positions never reach the mask
  assign wr_mask_bits = CMD_WDATA & MASK_VALID; // RULE_17 RULE_23

  // ********************************
  // next state
  // ********************************
  always_comb begin
    next_s = s;
    next_s.resume_d = resume_sync;
    // no token goes out on the bus while processing is halted
    next_s.sof = FRAME_START & ~s.halt; // RULE_10 RULE_14
    next_s.rd_valid = 1'b0;
    // clear first, then set, so a same-cycle event survives
    if (wr_flags) begin
      next_s.flags = s.flags & ~CMD_WDATA; // RULE_03
    end
    next_s.flags = (next_s.flags | ev) & FLAG_VALID; // RULE_01 RULE_04 RULE_24
    if (wr_mask) begin
      next_s.mask = s.mask | wr_mask_bits; // RULE_18 RULE_20
    end else if (wr_mclr) begin
      next_s.mask = s.mask & ~wr_mask_bits; // RULE_21
    end
    // tally counts every overrun, wrapping 3 to 0
    if (SCHED_OVERRUN) begin
      next_s.tally = s.tally + TALLY_ONE; // RULE_16 RULE_22
    end
    // halt holds until the controller is reset with the error gone
    if (ev[BIT_FATAL_ERR]) begin
      next_s.halt = 1'b1; // RULE_10
    end else if (HC_SW_RESET) begin
      next_s.halt = 1'b0;
    end
    // reads have no side effect; unmapped codes read zero
    if (any_read) begin
      next_s.rd_valid = 1'b1;
      unique case (CMD_CODE)
        CMD_RD_FLAGS: next_s.rd_data = s.flags; // RULE_05
        CMD_RD_MASK: next_s.rd_data = s.mask; // RULE_19
        CMD_RD_MCLR: next_s.rd_data = s.mask; // RULE_21
        default: next_s.rd_data = 32'h00000000;
      endcase
    end
    // software reset of the controller clears flags, mask and tally
    if (HC_SW_RESET) begin
      next_s.flags = FLAGS_RST;
      next_s.mask = MASK_RST;
      next_s.tally = TALLY_RST;
    end
  end

  // ********************************
  // registers
  // ********************************
  // events seen while CE is low are not captured
  always_ff @(posedge CLK) begin
    if (SRST) begin
      s.flags <= FLAGS_RST;
      s.mask <= MASK_RST;
      s.tally <= TALLY_RST;
      s.halt <= 1'b0;
      s.sof <= 1'b0;
      s.rd_data <= 32'h00000000;
      s.rd_valid <= 1'b0;
      s.resume_d <= 1'b0;
    end else if (CE) begin
      s <= next_s;
    end
  end

  // ********************************
  // outputs
  // ********************************
  assign RD_DATA = s.rd_data;
  assign RD_VALID = s.rd_valid;
  assign SOF_TOKEN = s.sof;
  assign OVERRUN_TALLY = s.tally;
  assign PROCESS_HALT = s.halt;
  // three-way gate on registered state
  assign IRQ = s.mask[BIT_GLOBAL_EN] && |(s.flags & s.mask & FLAG_VALID); // RULE_02

  // ********************************
  // checks
  // ********************************
  a_event_sets_flag: assert property ( // RULE_01
    @(posedge CLK) disable iff (SRST)
    (CE && !HC_SW_RESET && |ev) |=> ((s.flags & $past(ev)) == ($past(ev) & FLAG_VALID))
  ) else $error("event did not set its flag");

  a_irq_needs_enable: assert property ( // RULE_02
    @(posedge CLK) disable iff (SRST)
    IRQ |-> (s.mask[BIT_GLOBAL_EN] && (s.flags & s.mask) != 32'h00000000)
  ) else $error("irq without enabled flag");

  a_clear_no_set: assert property ( // RULE_03
    @(posedge CLK) disable iff (SRST)
    (CE && wr_flags && !HC_SW_RESET && ev == 32'h00000000) |=>
      (s.flags == ($past(s.flags) & ~$past(CMD_WDATA)))
  ) else $error("flag write did not clear as written");

  a_flags_stay_set: assert property ( // RULE_04
    @(posedge CLK) disable iff (SRST)
    (CE && !wr_flags && !HC_SW_RESET) |=> ((s.flags & $past(s.flags)) == $past(s.flags))
  ) else $error("flag dropped without a clear");

  a_mask_set_ones: assert property ( // RULE_18
    @(posedge CLK) disable iff (SRST)
    (CE && wr_mask && !HC_SW_RESET) |=>
      (s.mask == ($past(s.mask) | $past(wr_mask_bits)))
  ) else $error("mask write not set-only");

  a_mask_clear_port: assert property ( // RULE_21
    @(posedge CLK) disable iff (SRST)
    (CE && wr_mclr) |=> ((s.mask & $past(wr_mask_bits)) == 32'h00000000)
  ) else $error("mask clear port left bits set");

  a_mask_read_back: assert property ( // RULE_19
    @(posedge CLK) disable iff (SRST)
    (CE && any_read && !HC_SW_RESET && CMD_CODE == CMD_RD_MASK) |=>
      (RD_VALID && RD_DATA == $past(s.mask) && $stable(s.mask))
  ) else $error("mask read wrong or had side effect");

  a_tally_counts: assert property ( // RULE_16
    @(posedge CLK) disable iff (SRST)
    (CE && SCHED_OVERRUN && !HC_SW_RESET) |=>
      (OVERRUN_TALLY == 2'($past(OVERRUN_TALLY) + TALLY_ONE) && s.flags[BIT_SO])
  ) else $error("overrun tally not bumped");

  a_error_halts: assert property ( // RULE_10
    @(posedge CLK) disable iff (SRST)
    (CE && SYS_ERROR) |=> PROCESS_HALT ##1 (PROCESS_HALT || $past(HC_SW_RESET))
  ) else $error("system error did not halt processing");

  a_sw_resume_quiet: assert property ( // RULE_13
    @(posedge CLK) disable iff (SRST)
    (CE && RESUME_ENTRY_SW && !s.flags[BIT_RD]) |=> !s.flags[BIT_RD]
  ) else $error("resume flag set by software entry");

  a_sof_token: assert property ( // RULE_14
    @(posedge CLK) disable iff (SRST)
    (CE && FRAME_START && !HC_SW_RESET && !PROCESS_HALT) |=>
      (SOF_TOKEN && s.flags[BIT_FRAME_START])
  ) else $error("frame start missed token or flag");

  a_reserved_zero: assert property ( // RULE_23
    @(posedge CLK) disable iff (SRST)
    ((s.flags & ~FLAG_VALID) == 32'h00000000) && ((s.mask & ~MASK_VALID) == 32'h00000000)
  ) else $error("reserved bit set");

  // paths from each event source into its flag and on to irq
  a_irq_follows_event: assert property ( // RULE_02
    @(posedge CLK) disable iff (SRST)
    (CE && !HC_SW_RESET && !wr_mclr && s.mask[BIT_GLOBAL_EN] &&
      (ev & s.mask) != 32'h00000000) |=> IRQ
  ) else $error("enabled event raised no irq");

  a_global_en_set: assert property ( // RULE_20
    @(posedge CLK) disable iff (SRST)
    (CE && wr_mask && CMD_WDATA[BIT_GLOBAL_EN] && !HC_SW_RESET) |=> s.mask[BIT_GLOBAL_EN]
  ) else $error("global enable not set by write");

  a_global_en_keep: assert property ( // RULE_20
    @(posedge CLK) disable iff (SRST)
    (CE && wr_mask && !CMD_WDATA[BIT_GLOBAL_EN] && !HC_SW_RESET) |=>
      (s.mask[BIT_GLOBAL_EN] == $past(s.mask[BIT_GLOBAL_EN]))
  ) else $error("zero write changed global enable");

  a_hub_sets_flag: assert property ( // RULE_07
    @(posedge CLK) disable iff (SRST)
    (CE && !HC_SW_RESET && (hub_chg || p1_chg || p2_chg)) |=> s.flags[BIT_HUB_CHANGE]
  ) else $error("hub change flag not set");

  a_wrap_sets_flag: assert property ( // RULE_08
    @(posedge CLK) disable iff (SRST)
    (CE && !HC_SW_RESET && wrap_chg) |=> s.flags[BIT_FRAME_WRAP]
  ) else $error("frame wrap flag not set");

  a_error_sets_flag: assert property ( // RULE_09
    @(posedge CLK) disable iff (SRST)
    (CE && SYS_ERROR && !HC_SW_RESET) |=> s.flags[BIT_FATAL_ERR]
  ) else $error("system error flag not set");

  a_resume_sets_flag: assert property ( // RULE_12
    @(posedge CLK) disable iff (SRST)
    (CE && !HC_SW_RESET && resume_sync && !s.resume_d && !RESUME_ENTRY_SW) |=>
      s.flags[BIT_RD]
  ) else $error("resume flag not set");

  a_halt_no_sof: assert property ( // RULE_10
    @(posedge CLK) disable iff (SRST)
    (CE && PROCESS_HALT) |=> !SOF_TOKEN
  ) else $error("sof token sent while halted");

  a_tally_holds: assert property ( // RULE_22
    @(posedge CLK) disable iff (SRST)
    (CE && !SCHED_OVERRUN && !HC_SW_RESET) |=> $stable(OVERRUN_TALLY)
  ) else $error("tally moved without overrun");

  a_mclr_keeps_zeros: assert property ( // RULE_21
    @(posedge CLK) disable iff (SRST)
    (CE && wr_mclr && !HC_SW_RESET) |=>
      ((s.mask | $past(wr_mask_bits)) == ($past(s.mask) | $past(wr_mask_bits)))
  ) else $error("mask clear port touched zero bits");

  // read answers and same-cycle priorities
  a_flags_read_back: assert property ( // RULE_05
    @(posedge CLK) disable iff (SRST)
    (CE && any_read && CMD_CODE == CMD_RD_FLAGS) |=>
      (RD_VALID && RD_DATA == $past(s.flags))
  ) else $error("flag read returned wrong data");

  a_read_one_cycle: assert property ( // RULE_05
    @(posedge CLK) disable iff (SRST)
    (CE && !any_read) |=> !RD_VALID
  ) else $error("read answer without a read");

  a_set_beats_clear: assert property ( // RULE_24
    @(posedge CLK) disable iff (SRST)
    (CE && wr_flags && !HC_SW_RESET) |=> ((s.flags & $past(ev)) == $past(ev))
  ) else $error("event lost to a same-cycle clear");

  a_sw_reset_clears: assert property ( // RULE_04
    @(posedge CLK) disable iff (SRST)
    (CE && HC_SW_RESET) |=>
      (s.flags == FLAGS_RST && s.mask == MASK_RST && OVERRUN_TALLY == TALLY_RST)
  ) else $error("controller reset left state behind");
endmodule

/* dv/usbi_host_model.sv */
// host cpu model: issues register commands on the shared command bus
// assumes CLK rising edge sampling, one command per strobe cycle
`timescale 1ns/1ps
module usbi_host_model
  import usbi_pkg::*;
(
  input wire logic clk,
  input wire logic [31:0] rd_data,
  input wire logic rd_valid,
  output logic cmd_valid,
  output logic [7:0] cmd_code,
  output logic [31:0] cmd_wdata
);
  // ****************
  // bus cycles
  // ****************
  // bus starts at zero; after a write the code stays and the data lines show the inverted data
  initial begin
    cmd_valid = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 32'h0;
  end
  // write: ones clear flags, set mask bits, or clear mask bits via the clear port; zeros leave them
  task automatic wr(input logic [7:0] code, input logic [31:0] data);
    @(posedge clk) #1;
    cmd_valid = 1'b1;
    cmd_code = code;
    cmd_wdata = data;
    @(posedge clk) #1;
    cmd_valid = 1'b0;
    cmd_wdata = ~data;
  endtask
  // read: answer sampled in the cycle after the taking edge
  task automatic rd(input logic [7:0] code, output logic [31:0] d, output logic v);
    @(posedge clk) #1;
    cmd_valid = 1'b1;
    cmd_code = code;
    @(posedge clk) #1;
    cmd_valid = 1'b0;
    d = rd_data;
    v = rd_valid;
  endtask
endmodule

/* dv/tb_top.sv */
// testbench of the interrupt event flags block, driven by the host model
// assumes events are pulsed one clock long; CE drops in one test only
`timescale 1ns/1ps
module tb_top
  import usbi_pkg::*;
;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic swr = 1'b0;
  logic [2:0] ev = 3'h0; // overrun, frame start, system error
  logic res_pin = 1'b0;
  logic res_sw = 1'b0;
  logic [31:0] hub = 32'h0;
  logic [31:0] p1 = 32'h0;
  logic [31:0] p2 = 32'h0;
  logic [15:0] fn = 16'h0;
  logic cv;
  logic [7:0] cc;
  logic [31:0] cw;
  logic [31:0] rdd;
  logic rdv;
  logic sof;
  logic [1:0] tally;
  logic halt;
  logic irq;
  logic [31:0] d;
  logic v;
  int errors = 0;
  int check_count = 0;
  always #4 clk = ~clk;
  usbi_top DUT (.CLK(clk), .CE(ce), .SRST(srst), .HC_SW_RESET(swr), .CMD_VALID(cv),
    .CMD_CODE(cc), .CMD_WDATA(cw), .RD_DATA(rdd), .RD_VALID(rdv), .HUB_STATE(hub),
    .PORT1_STATE(p1), .PORT2_STATE(p2), .FRAME_NUMBER(fn), .SYS_ERROR(ev[2]),
    .RESUME_PIN(res_pin), .RESUME_ENTRY_SW(res_sw), .FRAME_START(ev[1]),
    .SCHED_OVERRUN(ev[0]), .SOF_TOKEN(sof), .OVERRUN_TALLY(tally),
    .PROCESS_HALT(halt), .IRQ(irq));
  usbi_host_model host (.clk(clk), .rd_data(rdd), .rd_valid(rdv), .cmd_valid(cv),
    .cmd_code(cc), .cmd_wdata(cw));
  // ****************
  // helpers
  // ****************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] code, input logic [31:0] exp);
    host.rd(code, d, v);
    chk("rd_valid", {31'h0, v}, 32'h1);
    chk(nm, d, exp);
  endtask
  task automatic pulse(input int i);
    @(posedge clk) #1;
    ev[i] = 1'b1;
    @(posedge clk) #1;
    ev[i] = 1'b0;
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // tests take under a hundred cycles; the 2500-cycle limit means a hang
  initial begin
    #20000;
    errors++;
    wrap_up();
  end
  // ****************
  // tests
  // ****************
  initial begin
    repeat (3) @(posedge clk);
    #1 srst = 1'b0;
    rd_chk("flags", CMD_RD_FLAGS, FLAGS_RST);
    rd_chk("mask", CMD_RD_MASK, MASK_RST);
    rd_chk("unmapped", 8'h0d, 32'h0);
    host.wr(CMD_WR_MASK, 32'h7fffff82);
    rd_chk("mask", CMD_RD_MASK, 32'h0);
    host.wr(CMD_WR_MASK, 32'h5);
    host.wr(CMD_WR_MASK, 32'h40);
    host.wr(CMD_WR_MASK, 32'h0);
    rd_chk("mask", CMD_RD_MCLR, 32'h45);
    rd_chk("mask", CMD_RD_MASK, 32'h45);
    $display("test mask done");
    pulse(1);
    chk("sof", {31'h0, sof}, 32'h1);
    chk("irq", {31'h0, irq}, 32'h0);
    host.wr(CMD_WR_MASK, 32'h80000000);
    chk("irq", {31'h0, irq}, 32'h1);
    host.wr(CMD_WR_MCLR, 32'h4);
    chk("irq", {31'h0, irq}, 32'h0);
    rd_chk("mask", CMD_RD_MCLR, 32'h80000041);
    pulse(0);
    chk("tally", {30'h0, tally}, 32'h1);
    chk("irq", {31'h0, irq}, 32'h1);
    pulse(2);
    chk("halt", {31'h0, halt}, 32'h1);
    fn = 16'h8000;
    hub = 32'h1;
    res_pin = 1'b1;
    wait_n(4);
    rd_chk("flags", CMD_RD_FLAGS, 32'h7d);
    $display("test events done");
    host.wr(CMD_WR_FLAGS, 32'h6f);
    rd_chk("flags", CMD_RD_FLAGS, 32'h10);
    fn = 16'h0;
    p2 = 32'h5;
    wait_n(2);
    host.wr(CMD_WR_FLAGS, 32'h0);
    wait_n(5);
    rd_chk("flags", CMD_RD_FLAGS, 32'h70);
    pulse(1);
    chk("sof", {31'h0, sof}, 32'h0);
    fork
      host.wr(CMD_WR_FLAGS, 32'h4);
      pulse(1);
    join
    rd_chk("flags", CMD_RD_FLAGS, 32'h74);
    for (int i = 2; i < 5; i++) begin
      pulse(0);
      chk("tally", {30'h0, tally}, i % 4);
    end
    res_sw = 1'b1;
    res_pin = 1'b0;
    wait_n(4);
    res_pin = 1'b1;
    wait_n(5);
    rd_chk("flags", CMD_RD_FLAGS, 32'h75);
    res_sw = 1'b0;
    chk("halt", {31'h0, halt}, 32'h1);
    $display("test clear done");
    swr = 1'b1;
    @(posedge clk) #1;
    swr = 1'b0;
    chk("halt", {31'h0, halt}, 32'h0);
    chk("tally", {30'h0, tally}, 32'h0);
    chk("irq", {31'h0, irq}, 32'h0);
    host.wr(CMD_WR_FLAGS, 32'h10);
    rd_chk("flags", CMD_RD_FLAGS, 32'h0);
    rd_chk("mask", CMD_RD_MASK, 32'h0);
    $display("test soft reset done");
    // events while the clock enable is low must leave no trace
    ce = 1'b0;
    pulse(0);
    pulse(1);
    ce = 1'b1;
    chk("tally", {30'h0, tally}, 32'h0);
    chk("sof", {31'h0, sof}, 32'h0);
    rd_chk("flags", CMD_RD_FLAGS, 32'h0);
    $display("test clock enable done");
    wrap_up();
  end
endmodule
